//--- common/wcr_ctl_if.sv
// Control carrier between the register front end and its two flag keepers
`timescale 1ns/1ps
`default_nettype none
interface wcr_ctl_if;
  import wcr_pkg::*;
  logic clear_stb;
  wcr_code_t clear_code;
  logic cause_wr;
  wcr_cause_t cause_wdata;
  wcr_cause_t cause_q;
  modport ctl (output clear_stb, clear_code, cause_wr, cause_wdata, input cause_q);
  modport wake (input clear_stb, clear_code);
  modport cause (input cause_wr, cause_wdata, output cause_q);
endinterface
`default_nettype wire

//--- common/wcr_defs.svh
// Register offsets, field positions and reset values of the wakeup clear and reset flag block
`ifndef WCR_DEFS_SVH
`define WCR_DEFS_SVH

`define WCR_ADDR_W 12
`define WCR_OFF_CLEAR 12'h000
`define WCR_OFF_NMI 12'h004
`define WCR_OFF_CAUSE 12'h008

`define WCR_CODE_W 5
`define WCR_NUM_SRC 22
`define WCR_CODE_LAST 5'h15

`define WCR_NMI_W 2
`define WCR_NMI_WDT_BIT 0
`define WCR_NMI_PIN_BIT 1

`define WCR_CAUSE_W 5
`define WCR_PON_BIT 0
`define WCR_PIN_BIT 1
`define WCR_WDT_BIT 2
`define WCR_BUP_BIT 3
`define WCR_DBG_BIT 4
`define WCR_CAUSE_RST 5'h01
`define WCR_RST_SRC_W 4

`endif

//--- common/wcr_pkg.sv
// Types shared by the wakeup clear and reset flag block
`default_nettype none
package wcr_pkg;
`include "wcr_defs.svh"

  typedef logic [`WCR_CODE_W-1:0] wcr_code_t;
  typedef logic [`WCR_CAUSE_W-1:0] wcr_cause_t;
  typedef logic [`WCR_NMI_W-1:0] wcr_nmi_t;

  typedef enum logic [0:0] {
    WCR_IDLE = 1'b0,
    WCR_ANSWER = 1'b1
  } wcr_apb_e;
endpackage
`default_nettype wire

//--- hw/wcr_reset_cause.sv
// Reset cause flags, kept alive across every reset but power-on
`timescale 1ns/1ps
`default_nettype none
`include "wcr_defs.svh"
module wcr_reset_cause (
  input wire logic pclk,
  input wire logic por_n,
  input wire logic [`WCR_RST_SRC_W-1:0] rst_src,
  wcr_ctl_if.cause c
);
  import wcr_pkg::*;

  typedef struct packed {
    logic [`WCR_RST_SRC_W-1:0] s0;
    logic [`WCR_RST_SRC_W-1:0] s1;
    logic [`WCR_RST_SRC_W-1:0] s2;
    logic [`WCR_RST_SRC_W-1:0] lvl;
    wcr_cause_t flags;
  } wcr_cause_s;

  wcr_cause_s r_reg;
  wcr_cause_s r_next;
  logic [`WCR_RST_SRC_W-1:0] rise;

  assign rise = r_reg.s1 & r_reg.s2 & ~r_reg.lvl;

  always_comb begin
    r_next = r_reg;
    r_next.s0 = rst_src;
    r_next.s1 = r_reg.s0;
    r_next.s2 = r_reg.s1;
    for (int i = 0; i < `WCR_RST_SRC_W; i++) begin
      if (r_reg.s1[i] == r_reg.s2[i]) begin
        r_next.lvl[i] = r_reg.s2[i];
      end
    end
    if (c.cause_wr) begin
      r_next.flags = r_reg.flags & c.cause_wdata; // [R11]
    end
    // Set wins over a software clear in the same cycle
    r_next.flags[`WCR_PIN_BIT] = r_next.flags[`WCR_PIN_BIT] | rise[0]; // [R7]
    r_next.flags[`WCR_WDT_BIT] = r_next.flags[`WCR_WDT_BIT] | rise[1]; // [R7]
    r_next.flags[`WCR_BUP_BIT] = r_next.flags[`WCR_BUP_BIT] | rise[2]; // [R6]
    r_next.flags[`WCR_DBG_BIT] = r_next.flags[`WCR_DBG_BIT] | rise[3]; // [R5]
  end

  // Only power-on resets this state [R9] [R10]
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      r_reg <= {{(4*`WCR_RST_SRC_W){1'b0}}, `WCR_CAUSE_RST}; // [R8]
    end else begin
      r_reg <= r_next;
    end
  end

  assign c.cause_q = r_reg.flags;
endmodule
`default_nettype wire

//--- hw/wcr_top.sv
// APB register front end of the wakeup clear, nonmaskable source and reset cause flags
//
// Operation
// R1: Writing a valid 5-bit clear code clears that one latched wakeup request.
// R2: Nonmaskable pin event sets source flag bit 1.
// R3: Watchdog nonmaskable event sets source flag bit 0.
// R4: Reading the nonmaskable source register clears both flags; no write needed.
// R5: Processor system reset request sets debug reset cause bit 4.
// R6: Leaving backup low-power mode sets reset cause bit 3.
// R7: Reset pin sets cause bit 1; watchdog reset sets cause bit 2.
// R8: Power-on reset leaves the power-on cause bit 0 at one.
// R9: Only power-on reset initializes the reset cause register.
// R10: Later resets never set power-on bit; register never clears itself.
// R11: Software clears reset cause flags by writing zero to them.
// R12: A clear code also clears that source's detected-edge status.
// R13: Reserved clear codes do nothing; clear register reads zero.
`timescale 1ns/1ps
`default_nettype none
`include "wcr_defs.svh"
module wcr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic [`WCR_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nmi_pin,
  input wire logic nmi_wdt,
  input wire logic [`WCR_NUM_SRC-1:0] wake_src,
  input wire logic [`WCR_RST_SRC_W-1:0] rst_src,
  output logic [`WCR_NUM_SRC-1:0] wake_pending,
  output logic [2*`WCR_NUM_SRC-1:0] edge_status,
  output wcr_pkg::wcr_nmi_t nmi_flags,
  output wcr_pkg::wcr_cause_t cause_flags
);
  import wcr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    wcr_apb_e st;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    wcr_nmi_t nmi;
    wcr_nmi_t nmi_seen;
    logic [2:0] pin_sync;
    logic pin_lvl;
    logic clr_stb;
    wcr_code_t clr_code;
    logic cause_wr;
    wcr_cause_t cause_wdata;
  } wcr_top_s;

  wcr_top_s r_reg;
  wcr_top_s r_next;
  wcr_ctl_if c ();

  logic pin_rise;
  logic done;
  logic mapped;
  wcr_code_t wr_code;

  // ----------------------------------------------------------------
  // Flag keepers
  // ----------------------------------------------------------------
  wcr_wake_latch #(
    .NUM_SRC(`WCR_NUM_SRC)
  ) u_wake (
    .pclk(pclk),
    .presetn(presetn),
    .wake_src(wake_src),
    .c(c.wake),
    .pending(wake_pending),
    .edge_status(edge_status)
  );

  // Runs on por_n alone so that pin, watchdog, backup and debug resets
  // cannot wipe the cause history
  wcr_reset_cause u_cause (
    .pclk(pclk),
    .por_n(por_n),
    .rst_src(rst_src),
    .c(c.cause)
  );

  assign c.clear_stb = r_reg.clr_stb;
  assign c.clear_code = r_reg.clr_code;
  assign c.cause_wr = r_reg.cause_wr;
  assign c.cause_wdata = r_reg.cause_wdata;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  assign pin_rise = r_reg.pin_sync[1] & r_reg.pin_sync[2] & ~r_reg.pin_lvl;
  assign done = psel & penable & r_reg.ready;
  assign mapped = (paddr == `WCR_OFF_CLEAR) || (paddr == `WCR_OFF_NMI)
    || (paddr == `WCR_OFF_CAUSE);
  assign wr_code = pwdata[`WCR_CODE_W-1:0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.clr_stb = 1'b0;
    r_next.cause_wr = 1'b0;
    r_next.pin_sync = {r_reg.pin_sync[1:0], nmi_pin};
    if (r_reg.pin_sync[1] == r_reg.pin_sync[2]) begin
      r_next.pin_lvl = r_reg.pin_sync[2];
    end
    case (r_reg.st)
      WCR_IDLE: begin
        r_next.ready = 1'b0;
        r_next.slverr = 1'b0;
        if (psel && penable) begin
          // One wait state so that read data leaves a flip-flop
          r_next.st = WCR_ANSWER;
          r_next.ready = 1'b1;
          r_next.rdata = 32'h0000_0000;
          r_next.nmi_seen = 2'h0;
          case (paddr)
            `WCR_OFF_CLEAR: begin
              r_next.rdata = 32'h0000_0000; // [R13]
            end
            `WCR_OFF_NMI: begin
              if (!pwrite) begin
                r_next.rdata[`WCR_NMI_W-1:0] = r_reg.nmi;
                r_next.nmi_seen = r_reg.nmi;
              end
            end
            `WCR_OFF_CAUSE: begin
              if (!pwrite) begin
                r_next.rdata[`WCR_CAUSE_W-1:0] = c.cause_q;
              end
            end
            default: begin
              r_next.slverr = 1'b1;
            end
          endcase
        end
      end
      WCR_ANSWER: begin
        r_next.st = WCR_IDLE;
        r_next.ready = 1'b0;
        r_next.slverr = 1'b0;
        if (pwrite && !r_reg.slverr) begin
          case (paddr)
            `WCR_OFF_CLEAR: begin
              if (wr_code <= `WCR_CODE_LAST) begin // [R13]
                r_next.clr_stb = 1'b1; // [R1]
                r_next.clr_code = wr_code;
              end
            end
            `WCR_OFF_CAUSE: begin
              r_next.cause_wr = 1'b1; // [R11]
              r_next.cause_wdata = pwdata[`WCR_CAUSE_W-1:0];
            end
            default: begin
              r_next.cause_wr = 1'b0;
            end
          endcase
        end
        // Only bits that were returned are dropped; later events stay
        if (!pwrite && paddr == `WCR_OFF_NMI) begin
          r_next.nmi = r_reg.nmi & ~r_reg.nmi_seen; // [R4]
        end
      end
      default: begin
        r_next.st = WCR_IDLE;
        r_next.ready = 1'b0;
      end
    endcase
    // Sources win over the read-clear in the same cycle
    if (nmi_wdt) begin
      r_next.nmi[`WCR_NMI_WDT_BIT] = 1'b1; // [R3]
    end
    if (pin_rise) begin
      r_next.nmi[`WCR_NMI_PIN_BIT] = 1'b1; // [R2]
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.rdata;
  assign pready = r_reg.ready;
  assign pslverr = r_reg.slverr;
  assign nmi_flags = r_reg.nmi;
  assign cause_flags = c.cause_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_ready_one_cycle: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready stood longer than one cycle");

  chk_answer_after_wait: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait state");

  chk_unmapped_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    done && !mapped |-> pslverr)
    else $error("unmapped address answered without error");

  chk_clear_code_pass: assert property ( // [R1]
    @(posedge pclk) disable iff (!presetn)
    done && pwrite && paddr == `WCR_OFF_CLEAR && wr_code <= `WCR_CODE_LAST
    |=> c.clear_stb && c.clear_code == $past(wr_code) ##1 !c.clear_stb)
    else $error("valid clear code not passed on as one pulse");

  chk_reserved_code: assert property ( // [R13]
    @(posedge pclk) disable iff (!presetn)
    done && pwrite && paddr == `WCR_OFF_CLEAR && wr_code > `WCR_CODE_LAST
    |=> !c.clear_stb)
    else $error("reserved clear code produced a clear");

  chk_clear_reads_zero: assert property ( // [R13]
    @(posedge pclk) disable iff (!presetn)
    done && !pwrite && paddr == `WCR_OFF_CLEAR |-> prdata == 32'h0000_0000)
    else $error("clear register read not zero");

  chk_nmi_pin_set: assert property ( // [R2]
    @(posedge pclk) disable iff (!presetn)
    $rose(r_reg.pin_lvl) |-> nmi_flags[`WCR_NMI_PIN_BIT])
    else $error("accepted pin event did not set pin source flag");

  chk_nmi_wdt_set: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    nmi_wdt |=> nmi_flags[`WCR_NMI_WDT_BIT])
    else $error("watchdog event did not set watchdog source flag");

  chk_nmi_read_clear: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    done && !pwrite && paddr == `WCR_OFF_NMI && nmi_flags == prdata[1:0]
    && !nmi_wdt && !pin_rise |=> nmi_flags == 2'h0)
    else $error("nonmaskable flags not cleared by read");

  chk_nmi_flags_hold: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    nmi_flags[`WCR_NMI_WDT_BIT] && !(done && paddr == `WCR_OFF_NMI)
    |=> nmi_flags[`WCR_NMI_WDT_BIT])
    else $error("watchdog source flag lost without a read");

  chk_nmi_write_ignored: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    done && pwrite && paddr == `WCR_OFF_NMI && !nmi_wdt && !pin_rise
    |=> nmi_flags == $past(nmi_flags))
    else $error("write to nonmaskable source register changed flags");

  chk_cause_read_back: assert property (
    @(posedge pclk) disable iff (!presetn)
    done && !pwrite && paddr == `WCR_OFF_CAUSE |-> prdata == {27'h0, $past(cause_flags)})
    else $error("reset cause read did not return the flags");

  chk_pon_never_sets: assert property ( // [R10]
    @(posedge pclk) disable iff (!por_n)
    !cause_flags[`WCR_PON_BIT] |=> !cause_flags[`WCR_PON_BIT])
    else $error("power-on cause flag set again after power-up");

  chk_cause_survives: assert property ( // [R9]
    @(posedge pclk) disable iff (!por_n)
    !presetn |=> (cause_flags & $past(cause_flags)) == $past(cause_flags))
    else $error("cause flags lost under a non power-on reset");

  chk_cause_write_zero: assert property ( // [R11]
    @(posedge pclk) disable iff (!presetn || !por_n)
    done && pwrite && paddr == `WCR_OFF_CAUSE && !pwdata[`WCR_PON_BIT]
    |-> ##2 !cause_flags[`WCR_PON_BIT])
    else $error("writing zero did not clear the power-on cause flag");
endmodule
`default_nettype wire

//--- hw/wcr_wake_latch.sv
// Latched standby-release requests and their detected-edge status
`timescale 1ns/1ps
`default_nettype none
`include "wcr_defs.svh"
module wcr_wake_latch #(
  parameter int NUM_SRC = `WCR_NUM_SRC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NUM_SRC-1:0] wake_src,
  wcr_ctl_if.wake c,
  output logic [NUM_SRC-1:0] pending,
  output logic [2*NUM_SRC-1:0] edge_status
);
  import wcr_pkg::*;

  if (NUM_SRC < 1 || NUM_SRC > (1 << `WCR_CODE_W)) begin : g_bad_num
    $error("NUM_SRC must fit the clear code width");
  end

  typedef struct packed {
    logic [NUM_SRC-1:0] s0;
    logic [NUM_SRC-1:0] s1;
    logic [NUM_SRC-1:0] s2;
    logic [NUM_SRC-1:0] lvl;
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0][1:0] edg;
  } wcr_wake_s;

  wcr_wake_s r_reg;
  wcr_wake_s r_next;
  logic [NUM_SRC-1:0] chg;

  // Change accepted once second and third stage agree
  assign chg = ~(r_reg.s1 ^ r_reg.s2) & (r_reg.s2 ^ r_reg.lvl);

  always_comb begin
    r_next = r_reg;
    r_next.s0 = wake_src;
    r_next.s1 = r_reg.s0;
    r_next.s2 = r_reg.s1;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (c.clear_stb && c.clear_code == 5'(i)) begin
        r_next.pend[i] = 1'b0; // [R1] [R13]
        r_next.edg[i] = 2'h0; // [R12]
      end
      // A new edge in the clearing cycle survives the clear
      if (chg[i]) begin
        r_next.lvl[i] = r_reg.s2[i];
        r_next.pend[i] = 1'b1;
        r_next.edg[i][r_reg.s2[i] ? 0 : 1] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pending = r_reg.pend;
  assign edge_status = r_reg.edg;

  chk_clear_drops_edge: assert property ( // [R12]
    @(posedge pclk) disable iff (!presetn)
    c.clear_stb && c.clear_code < 5'(NUM_SRC) && chg == '0
    |=> pending[$past(c.clear_code)] == 1'b0 && r_reg.edg[$past(c.clear_code)] == 2'h0)
    else $error("clear code did not drop request and edge status");
endmodule
`default_nettype wire

//--- testbench/test_wakeup_clear_nmi_reset_flags.sv
// Self-checking bench of the wakeup clear, nonmaskable source and reset cause register block
`timescale 1ns/1ps
`default_nettype none
`include "wcr_defs.svh"

`define CHK(act, exp) begin \
  num_checks++; \
  if ((act) !== (exp)) begin \
    err_total++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (act), (exp)); \
  end \
end

module test_wakeup_clear_nmi_reset_flags;
  import wcr_pkg::*;
  logic pclk;
  logic presetn;
  logic por_n;
  logic [`WCR_ADDR_W-1:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic nmi_pin;
  logic nmi_wdt;
  logic [`WCR_NUM_SRC-1:0] wake_src;
  logic [`WCR_RST_SRC_W-1:0] rst_src;
  logic [`WCR_NUM_SRC-1:0] wake_pending;
  logic [2*`WCR_NUM_SRC-1:0] edge_status;
  wcr_nmi_t nmi_flags;
  wcr_cause_t cause_flags;
  logic [31:0] rd_data;
  logic rd_err;
  int err_total;
  int num_checks;
  int cycles;

  wcr_top dut (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nmi_pin(nmi_pin), .nmi_wdt(nmi_wdt),
    .wake_src(wake_src), .rst_src(rst_src), .wake_pending(wake_pending),
    .edge_status(edge_status), .nmi_flags(nmi_flags), .cause_flags(cause_flags)
  );

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic [`WCR_ADDR_W-1:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only pready or the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic bus_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic check_power_up();
    `CHK(cause_flags, 5'h01)
    apb(`WCR_OFF_CAUSE, 1'b0, 32'h0);
    `CHK(rd_data, 32'h0000_0001)
    apb(`WCR_OFF_CLEAR, 1'b0, 32'h0);
    `CHK(rd_data, 32'h0000_0000)
    apb(12'h00C, 1'b0, 32'h0);
    `CHK(rd_err, 1'b1)
    `CHK(rd_data, 32'h0000_0000)
  endtask

  task automatic check_nmi_sources();
    @(posedge pclk);
    nmi_wdt <= 1'b1;
    @(posedge pclk);
    nmi_wdt <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(nmi_flags, 2'b01)
    nmi_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK(nmi_flags, 2'b11)
    apb(`WCR_OFF_NMI, 1'b1, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK(nmi_flags, 2'b11)
    apb(`WCR_OFF_NMI, 1'b0, 32'h0);
    `CHK(rd_data, 32'h0000_0003)
    repeat (2) @(posedge pclk);
    `CHK(nmi_flags, 2'b00)
    apb(`WCR_OFF_NMI, 1'b0, 32'h0);
    `CHK(rd_data, 32'h0000_0000)
    nmi_pin <= 1'b0;
  endtask

  task automatic check_wake_clear();
    logic [`WCR_NUM_SRC-1:0] exp_pend;
    logic [2*`WCR_NUM_SRC-1:0] exp_edge;
    exp_pend = 22'h3F_FFFF;
    exp_edge = 44'h555_5555_5555;
    @(posedge pclk);
    wake_src <= 22'h3F_FFFF;
    repeat (6) @(posedge pclk);
    `CHK(wake_pending, exp_pend)
    `CHK(edge_status, exp_edge)
    // Every reserved code, with junk in the upper bits as well
    for (int c = 22; c < 32; c++) begin
      apb(`WCR_OFF_CLEAR, 1'b1, {27'h7FF_FFFF, c[4:0]});
    end
    repeat (2) @(posedge pclk);
    `CHK(wake_pending, exp_pend)
    `CHK(edge_status, exp_edge)
    for (int c = 0; c < 22; c++) begin
      apb(`WCR_OFF_CLEAR, 1'b1, {27'h0, c[4:0]});
      `CHK(rd_err, 1'b0)
      repeat (2) @(posedge pclk);
      exp_pend[c] = 1'b0;
      exp_edge[2*c +: 2] = 2'b00;
      `CHK(wake_pending, exp_pend)
      `CHK(edge_status, exp_edge)
    end
    // Falling edges latch too and report in the upper status bit
    wake_src <= 22'h00_0000;
    repeat (6) @(posedge pclk);
    `CHK(wake_pending, 22'h3F_FFFF)
    `CHK(edge_status, 44'hAAA_AAAA_AAAA)
    apb(`WCR_OFF_CLEAR, 1'b1, 32'h0000_0015);
    repeat (2) @(posedge pclk);
    `CHK(wake_pending, 22'h1F_FFFF)
    `CHK(edge_status, 44'h2AA_AAAA_AAAA)
    apb(`WCR_OFF_CLEAR, 1'b0, 32'h0);
    `CHK(rd_data, 32'h0000_0000)
  endtask

  task automatic check_reset_cause();
    wcr_cause_t exp_c;
    exp_c = 5'h01;
    for (int j = 0; j < 4; j++) begin
      @(posedge pclk);
      rst_src[j] <= 1'b1;
      repeat (6) @(posedge pclk);
      exp_c[j+1] = 1'b1;
      `CHK(cause_flags, exp_c)
    end
    rst_src <= 4'h0;
    bus_reset();
    `CHK(cause_flags, 5'h1F)
    // Ones written are harmless, only zeros clear
    apb(`WCR_OFF_CAUSE, 1'b1, 32'hFFFF_FFFE);
    repeat (3) @(posedge pclk);
    `CHK(cause_flags, 5'h1E)
    apb(`WCR_OFF_CAUSE, 1'b1, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK(cause_flags, 5'h00)
    bus_reset();
    @(posedge pclk);
    rst_src[0] <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK(cause_flags, 5'h02)
    rst_src <= 4'h0;
    repeat (40) @(posedge pclk);
    apb(`WCR_OFF_CAUSE, 1'b0, 32'h0);
    `CHK(rd_data, 32'h0000_0002)
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    err_total = 0;
    num_checks = 0;
    cycles = 0;
    presetn = 1'b0;
    por_n = 1'b0;
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    nmi_pin = 1'b0;
    nmi_wdt = 1'b0;
    wake_src = '0;
    rst_src = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    check_power_up();
    check_nmi_sources();
    check_wake_clear();
    check_reset_cause();
    print_verdict();
  end
endmodule
`default_nettype wire
